/* inc/bcfg_pkg.sv */
package bcfg_pkg;

  // supply-drop configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic       en;
    logic       rsv6;
    logic [1:0] thr;
    logic       inhibit;
    logic       rst_en;
    logic [1:0] rsv10;
  } bcfg_drop_s;

  // watchdog configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] code;
    logic [3:0] rsv;
  } bcfg_wdt_s;

  // one write coming out of the programming link
  typedef struct packed {
    logic       wr;
    logic       sel;
    logic [7:0] data;
  } bcfg_icp_wr_s;

  typedef enum logic [1:0] {
    BCFG_WDT_DISABLED,
    BCFG_WDT_RUN_LP_STOP,
    BCFG_WDT_RUN_ALWAYS
  } bcfg_wdt_mode_e;

  typedef enum logic [1:0] {
    BCFG_ICP_CMD,
    BCFG_ICP_WDATA,
    BCFG_ICP_RDATA
  } bcfg_icp_state_e;

  // un-programmed bytes read as all ones
  localparam logic [7:0]  BCFG_DROP_DEFAULT  = 8'hFF;
  localparam logic [7:0]  BCFG_WDT_DEFAULT   = 8'hFF;
  localparam logic [3:0]  BCFG_WDT_OFF       = 4'hF;
  localparam logic [3:0]  BCFG_WDT_STOP_LP   = 4'h5;

  localparam logic [1:0]  BCFG_THR_2V2       = 2'h3;
  localparam logic [1:0]  BCFG_THR_2V7       = 2'h2;
  localparam logic [1:0]  BCFG_THR_3V7       = 2'h1;
  localparam logic [12:0] BCFG_MV_2V2        = 13'h0898;
  localparam logic [12:0] BCFG_MV_2V7        = 13'h0A8C;
  localparam logic [12:0] BCFG_MV_3V7        = 13'h0E74;
  localparam logic [12:0] BCFG_MV_4V4        = 13'h1130;

  // programming frame: 8 command bits, then 8 data bits, msb first
  localparam int          BCFG_CMD_READ_BIT  = 7;
  localparam int          BCFG_CMD_SEL_BIT   = 0;
  localparam logic        BCFG_SEL_DROP      = 1'b0;
  localparam logic [2:0]  BCFG_LAST_BIT      = 3'h7;
  localparam logic [2:0]  BCFG_CNT_STEP      = 3'h1;

  function automatic bcfg_wdt_mode_e bcfg_wdt_decode(input logic [3:0] code);
    if (code == BCFG_WDT_OFF) begin
      return BCFG_WDT_DISABLED;
    end else if (code == BCFG_WDT_STOP_LP) begin
      return BCFG_WDT_RUN_LP_STOP;
    end else begin
      return BCFG_WDT_RUN_ALWAYS;
    end
  endfunction

  function automatic logic [12:0] bcfg_thr_mv(input logic [1:0] thr);
    case (thr)
      BCFG_THR_2V2: return BCFG_MV_2V2;
      BCFG_THR_2V7: return BCFG_MV_2V7;
      BCFG_THR_3V7: return BCFG_MV_3V7;
      default:      return BCFG_MV_4V4;
    endcase
  endfunction

endpackage

/* logic/bcfg_icp_shift.sv */
`timescale 1ns/1ps
module bcfg_icp_shift (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  // synchronised link levels
  input  wire logic                  prog_mode,
  input  wire logic                  clk_s,
  input  wire logic                  data_s,
  // stored bytes for readout
  input  wire logic [7:0]            rd_drop,
  input  wire logic [7:0]            rd_wdt,
  // write towards storage
  output bcfg_pkg::bcfg_icp_wr_s     wr,
  // data pin drive
  output logic                       data_out,
  output logic                       data_oe_n
);
  import bcfg_pkg::*;

  bcfg_icp_state_e state_r, state_nxt;
  logic [2:0]      cnt_r, cnt_nxt;
  logic [7:0]      sh_r, sh_nxt;
  logic            sel_r, sel_nxt;
  logic            prev_r, prev_nxt;
  logic            dout_r, dout_nxt;
  logic            oe_n_r, oe_n_nxt;
  bcfg_icp_wr_s    wr_r, wr_nxt;
  logic            rise;
  logic            fall;

  assign rise      = clk_s & ~prev_r;
  assign fall      = ~clk_s & prev_r;
  assign wr        = wr_r;
  assign data_out  = dout_r;
  assign data_oe_n = oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    sh_nxt    = sh_r;
    sel_nxt   = sel_r;
    prev_nxt  = clk_s;
    dout_nxt  = dout_r;
    oe_n_nxt  = oe_n_r;
    wr_nxt    = '{wr: 1'b0, sel: sel_r, data: sh_r};
    if (!prog_mode) begin
      // leaving the mode aborts any half frame
      state_nxt = BCFG_ICP_CMD; // R9
      cnt_nxt   = '0;
      oe_n_nxt  = 1'b1;
    end else begin
      case (state_r)
        BCFG_ICP_CMD: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], data_s}; // R11
            cnt_nxt = cnt_r + BCFG_CNT_STEP;
            if (cnt_r == BCFG_LAST_BIT) begin
              cnt_nxt = '0;
              sel_nxt = sh_nxt[BCFG_CMD_SEL_BIT];
              if (sh_nxt[BCFG_CMD_READ_BIT]) begin
                state_nxt = BCFG_ICP_RDATA;
                sh_nxt    = (sel_nxt == BCFG_SEL_DROP) ? rd_drop : rd_wdt;
              end else begin
                state_nxt = BCFG_ICP_WDATA;
              end
            end
          end
        end
        BCFG_ICP_WDATA: begin
          if (rise) begin
            sh_nxt  = {sh_r[6:0], data_s}; // R11
            cnt_nxt = cnt_r + BCFG_CNT_STEP;
            if (cnt_r == BCFG_LAST_BIT) begin
              cnt_nxt   = '0;
              state_nxt = BCFG_ICP_CMD;
              wr_nxt    = '{wr: 1'b1, sel: sel_r, data: sh_nxt};
            end
          end
        end
        BCFG_ICP_RDATA: begin
          // change on falling edge so the programmer samples on rising
          if (fall) begin
            dout_nxt = sh_r[7]; // R10
            oe_n_nxt = 1'b0; // R10
            sh_nxt   = {sh_r[6:0], 1'b0};
          end else if (rise) begin
            cnt_nxt = cnt_r + BCFG_CNT_STEP;
            if (cnt_r == BCFG_LAST_BIT) begin
              cnt_nxt   = '0;
              state_nxt = BCFG_ICP_CMD;
              oe_n_nxt  = 1'b1; // R10
            end
          end
        end
        default: begin
          state_nxt = BCFG_ICP_CMD;
          cnt_nxt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= BCFG_ICP_CMD;
      cnt_r   <= '0;
      sh_r    <= '0;
      sel_r   <= 1'b0;
      prev_r  <= 1'b0;
      dout_r  <= 1'b0;
      oe_n_r  <= 1'b1;
      wr_r    <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      sh_r    <= sh_nxt;
      sel_r   <= sel_nxt;
      prev_r  <= prev_nxt;
      dout_r  <= dout_nxt;
      oe_n_r  <= oe_n_nxt;
      wr_r    <= wr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_icp_release;
    @(posedge clock) disable iff (srst)
    !prog_mode |=> data_oe_n && cnt_r == '0;
  endproperty
  a_icp_release: assert property (p_icp_release) // R9
    else $error("data pin driven or count kept outside programming mode");

  property p_icp_drive_read_only;
    @(posedge clock) disable iff (srst)
    !data_oe_n |-> state_r == BCFG_ICP_RDATA
      || $past(state_r) == BCFG_ICP_RDATA;
  endproperty
  a_icp_drive_read_only: assert property (p_icp_drive_read_only) // R10
    else $error("data pin driven outside a readout");

  property p_icp_write_on_edge;
    @(posedge clock) disable iff (srst)
    wr.wr |-> $past(rise) && $past(state_r) == BCFG_ICP_WDATA
      && $past(cnt_r) == BCFG_LAST_BIT;
  endproperty
  a_icp_write_on_edge: assert property (p_icp_write_on_edge) // R11
    else $error("write not tied to the eighth data clock edge");

endmodule

/* logic/bcfg_loader.sv */
`timescale 1ns/1ps
// Overview of operation
// (R1) drop detection on when config bit 7 of drop byte is one
// (R2) bits 5:4 pick threshold: 11=2.2V, 10=2.7V, 01=3.7V, 00=4.4V
// (R3) inhibit bit blocks self-programming while supply below threshold
// (R4) inhibit acts only while drop detection is switched on
// (R5) bit 2 enables a system reset when supply falls below threshold
// (R6) watchdog code 1111 disables reset, timer free for software use
// (R7) code 0101 runs reset watchdog, stopped in idle and power-down
// (R8) any other code runs reset watchdog through idle and power-down
// (R9) reset pin low enters programming mode, high leaves it
// (R10) data pin is two-way: programmer writes, device drives on readout
// (R11) programmer supplies the clock; data shifts on its edges
// (R12) config bits are copied into run-time controls after reset
// (R13) programmer keeps reserved config bits un-programmed
// (R14) drop-related controls reload only on power-on reset
module bcfg_loader #(
  parameter logic [7:0] DROP_FACTORY = bcfg_pkg::BCFG_DROP_DEFAULT,
  parameter logic [7:0] WDT_FACTORY  = bcfg_pkg::BCFG_WDT_DEFAULT
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  por_cause,
  // in-circuit programming pins
  input  wire logic                  prog_reset_pin_n,
  input  wire logic                  prog_clock_pin,
  input  wire logic                  prog_data_pin_i,
  output logic                       prog_data_pin_o,
  output logic                       prog_data_pin_oe_n,
  // core status
  input  wire logic                  supply_below,
  input  wire logic                  low_power_mode,
  input  wire logic                  self_prog_req,
  // software access to run-time controls
  input  wire logic                  sw_drop_we,
  input  bcfg_pkg::bcfg_drop_s       sw_drop_wdata,
  input  wire logic                  sw_wdt_we,
  input  bcfg_pkg::bcfg_wdt_s        sw_wdt_wdata,
  // run-time controls and stored bytes
  output bcfg_pkg::bcfg_drop_s       drop_ctrl,
  output bcfg_pkg::bcfg_wdt_s        wdt_ctrl,
  output logic [7:0]                 supply_drop_config_byte,
  output logic [7:0]                 watchdog_config_byte,
  // decoded outputs
  output logic                       drop_detect_enable,
  output logic [1:0]                 drop_threshold_select,
  output logic [12:0]                drop_threshold_voltage,
  output logic                       low_supply_program_inhibit,
  output logic                       drop_reset_enable,
  output logic                       self_prog_grant,
  output logic                       drop_reset_req,
  output logic [3:0]                 watchdog_enable_code,
  output logic                       wdt_reset_enable,
  output logic                       wdt_gp_timer,
  output logic                       wdt_count_enable,
  output logic                       in_circuit_programming
);
  import bcfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: rst_n, clock, data, supply_below
  logic [3:0]   s1_r, s1_nxt;
  logic [3:0]   s2_r, s2_nxt;
  logic         mode_s;
  logic         pclk_s;
  logic         pdat_s;
  logic         below_s;

  always_comb begin
    s1_nxt = {prog_reset_pin_n, prog_clock_pin, prog_data_pin_i,
              supply_below};
    s2_nxt = s1_r;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_r <= 4'h8;
      s2_r <= 4'h8;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign mode_s  = ~s2_r[3]; // R9
  assign pclk_s  = s2_r[2];
  assign pdat_s  = s2_r[1];
  assign below_s = s2_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // programming link
  bcfg_icp_wr_s icp_wr;
  bcfg_drop_s   cfg_drop_r, cfg_drop_nxt;
  bcfg_wdt_s    cfg_wdt_r, cfg_wdt_nxt;

  bcfg_icp_shift u_shift (
    .clock     (clock),
    .srst      (srst),
    .prog_mode (mode_s),
    .clk_s     (pclk_s),
    .data_s    (pdat_s),
    .rd_drop   (cfg_drop_r),
    .rd_wdt    (cfg_wdt_r),
    .wr        (icp_wr),
    .data_out  (prog_data_pin_o),
    .data_oe_n (prog_data_pin_oe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // non-volatile image; bytes stored whole, reserved bits as written
  always_comb begin
    cfg_drop_nxt = cfg_drop_r;
    cfg_wdt_nxt  = cfg_wdt_r;
    if (icp_wr.wr && icp_wr.sel == BCFG_SEL_DROP) begin
      cfg_drop_nxt = icp_wr.data;
    end else if (icp_wr.wr) begin
      cfg_wdt_nxt = icp_wr.data;
    end
  end

  // only a power-on reset brings the model's image to factory state
  always_ff @(posedge clock) begin
    if (srst && por_cause) begin
      cfg_drop_r <= DROP_FACTORY;
      cfg_wdt_r  <= WDT_FACTORY;
    end else if (!srst) begin
      cfg_drop_r <= cfg_drop_nxt;
      cfg_wdt_r  <= cfg_wdt_nxt;
    end
  end

  assign supply_drop_config_byte = cfg_drop_r;
  assign watchdog_config_byte    = cfg_wdt_r;

  ////////////////////////////////////////////////////////////////////////////
  // run-time controls, loaded in the first cycle after reset release; drop controls only after a power-on reset
  logic         load_r, load_nxt;
  logic         por_r, por_nxt;
  bcfg_drop_s   drop_r, drop_nxt;
  bcfg_wdt_s    wdt_r, wdt_nxt;

  always_comb begin
    load_nxt = srst;
    por_nxt  = srst ? por_cause : por_r;
    drop_nxt = drop_r;
    wdt_nxt  = wdt_r;
    if (srst) begin
      wdt_nxt = WDT_FACTORY;
      if (por_cause) begin
        drop_nxt = DROP_FACTORY;
      end
    end else if (load_r) begin
      wdt_nxt = cfg_wdt_r; // R12
      if (por_r) begin
        drop_nxt = cfg_drop_r; // R14
      end
    end else begin
      if (sw_drop_we) begin
        drop_nxt = sw_drop_wdata; // R12
      end
      if (sw_wdt_we) begin
        wdt_nxt = sw_wdt_wdata; // R12
      end
    end
  end

  always_ff @(posedge clock) begin
    load_r <= load_nxt;
    por_r  <= por_nxt;
    drop_r <= drop_nxt;
    wdt_r  <= wdt_nxt;
  end

  assign drop_ctrl = drop_r;
  assign wdt_ctrl  = wdt_r;

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs, registered
  logic           det_r, det_nxt;
  logic [1:0]     thr_r, thr_nxt;
  logic [12:0]    mv_r, mv_nxt;
  logic           inh_r, inh_nxt;
  logic           rsten_r, rsten_nxt;
  logic           grant_r, grant_nxt;
  logic           dreq_r, dreq_nxt;
  logic [3:0]     code_r, code_nxt;
  logic           wrst_r, wrst_nxt;
  logic           wgp_r, wgp_nxt;
  logic           wcnt_r, wcnt_nxt;
  logic           icp_r, icp_nxt;
  logic           blocked;
  bcfg_wdt_mode_e wmode;

  always_comb begin
    wmode     = bcfg_wdt_decode(wdt_r.code);
    // detection off makes the inhibit bit meaningless
    blocked   = drop_r.en & drop_r.inhibit & below_s; // R3 R4
    det_nxt   = drop_r.en; // R1
    thr_nxt   = drop_r.thr; // R2
    mv_nxt    = bcfg_thr_mv(drop_r.thr); // R2
    inh_nxt   = drop_r.en & drop_r.inhibit; // R4
    rsten_nxt = drop_r.rst_en;
    grant_nxt = self_prog_req & ~blocked; // R3
    dreq_nxt  = drop_r.en & drop_r.rst_en & below_s; // R5
    code_nxt  = wdt_r.code;
    wrst_nxt  = wmode != BCFG_WDT_DISABLED; // R6
    wgp_nxt   = wmode == BCFG_WDT_DISABLED; // R6
    wcnt_nxt  = 1'b0;
    case (wmode)
      BCFG_WDT_RUN_LP_STOP: wcnt_nxt = ~low_power_mode; // R7
      BCFG_WDT_RUN_ALWAYS:  wcnt_nxt = 1'b1; // R8
      default:              wcnt_nxt = 1'b0;
    endcase
    icp_nxt   = mode_s; // R9
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      det_r   <= 1'b0;
      thr_r   <= '0;
      mv_r    <= '0;
      inh_r   <= 1'b0;
      rsten_r <= 1'b0;
      grant_r <= 1'b0;
      dreq_r  <= 1'b0;
      code_r  <= BCFG_WDT_OFF;
      wrst_r  <= 1'b0;
      wgp_r   <= 1'b0;
      wcnt_r  <= 1'b0;
      icp_r   <= 1'b0;
    end else begin
      det_r   <= det_nxt;
      thr_r   <= thr_nxt;
      mv_r    <= mv_nxt;
      inh_r   <= inh_nxt;
      rsten_r <= rsten_nxt;
      grant_r <= grant_nxt;
      dreq_r  <= dreq_nxt;
      code_r  <= code_nxt;
      wrst_r  <= wrst_nxt;
      wgp_r   <= wgp_nxt;
      wcnt_r  <= wcnt_nxt;
      icp_r   <= icp_nxt;
    end
  end

  assign drop_detect_enable         = det_r;
  assign drop_threshold_select      = thr_r;
  assign drop_threshold_voltage     = mv_r;
  assign low_supply_program_inhibit = inh_r;
  assign drop_reset_enable          = rsten_r;
  assign self_prog_grant            = grant_r;
  assign drop_reset_req             = dreq_r;
  assign watchdog_enable_code       = code_r;
  assign wdt_reset_enable           = wrst_r;
  assign wdt_gp_timer               = wgp_r;
  assign wdt_count_enable           = wcnt_r;
  assign in_circuit_programming     = icp_r;

  ////////////////////////////////////////////////////////////////////////////
  // load_r masks the release edge, where outputs still hold reset values
  property p_detect_follows;
    @(posedge clock) disable iff (srst || load_r)
    $changed(drop_r.en) |=> drop_detect_enable == $past(drop_r.en);
  endproperty
  a_detect_follows: assert property (p_detect_follows) // R1
    else $error("detect output did not follow control bit");

  property p_threshold_map;
    @(posedge clock) disable iff (srst || load_r)
    ##1 drop_threshold_voltage == bcfg_thr_mv($past(drop_r.thr))
      && drop_threshold_select == $past(drop_r.thr);
  endproperty
  a_threshold_map: assert property (p_threshold_map) // R2
    else $error("threshold output wrong for select code");

  property p_inhibit_blocks;
    @(posedge clock) disable iff (srst || load_r)
    drop_r.en && drop_r.inhibit && below_s && self_prog_req
      |=> !self_prog_grant;
  endproperty
  a_inhibit_blocks: assert property (p_inhibit_blocks) // R3
    else $error("self-programming granted below threshold");

  property p_inhibit_needs_detect;
    @(posedge clock) disable iff (srst || load_r)
    !drop_r.en && self_prog_req |=> self_prog_grant && !drop_reset_req;
  endproperty
  a_inhibit_needs_detect: assert property (p_inhibit_needs_detect) // R4
    else $error("inhibit or reset acted with detection off");

  property p_drop_reset;
    @(posedge clock) disable iff (srst)
    drop_reset_req |-> $past(drop_r.rst_en) && $past(below_s);
  endproperty
  a_drop_reset: assert property (p_drop_reset) // R5
    else $error("drop reset without enable or low supply");

  property p_wdt_off;
    @(posedge clock) disable iff (srst || load_r)
    wdt_r.code == BCFG_WDT_OFF
      |=> wdt_gp_timer && !wdt_reset_enable && !wdt_count_enable;
  endproperty
  a_wdt_off: assert property (p_wdt_off) // R6
    else $error("watchdog active with disable code");

  property p_wdt_lp_stop;
    @(posedge clock) disable iff (srst || load_r)
    wdt_r.code == BCFG_WDT_STOP_LP && low_power_mode
      |=> wdt_reset_enable && !wdt_count_enable;
  endproperty
  a_wdt_lp_stop: assert property (p_wdt_lp_stop) // R7
    else $error("watchdog counted in low power with stop code");

  property p_wdt_keep_running;
    @(posedge clock) disable iff (srst || load_r)
    wdt_r.code != BCFG_WDT_OFF && wdt_r.code != BCFG_WDT_STOP_LP
      |=> wdt_count_enable && wdt_reset_enable;
  endproperty
  a_wdt_keep_running: assert property (p_wdt_keep_running) // R8
    else $error("watchdog stopped with run-always code");

  property p_load_wdt;
    @(posedge clock) disable iff (srst)
    load_r && !srst |=> wdt_r == $past(cfg_wdt_r);
  endproperty
  a_load_wdt: assert property (p_load_wdt) // R12
    else $error("watchdog control not loaded after reset");

  property p_drop_por_only;
    @(posedge clock) disable iff (srst)
    load_r && !por_r |=> drop_r == $past(drop_r);
  endproperty
  a_drop_por_only: assert property (p_drop_por_only) // R14
    else $error("drop controls reloaded on a non power-on reset");

endmodule

/* tb/bcfg_prog_model.sv */
`timescale 1ns/1ps
module bcfg_prog_model (
  // programmer pins
  output logic      rst_pin_n,
  output logic      clk_pin,
  output logic      data_drv,
  // data line level as the programmer sees it
  input  wire logic data_pin
);
  initial begin
    rst_pin_n = 1'b1;
    clk_pin = 1'b0;
    data_drv = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one frame: 8 command bits then 8 data bits, msb first
  // nb below 16 drops out of the mode mid-frame
  // the clock stands still outside frames
  task automatic frame(input logic [7:0] cmd, input logic [7:0] dat,
                       input int nb, output logic [7:0] rd);
    rd = 8'h00;
    #401.3 rst_pin_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      if (i < 8) begin
        data_drv = cmd[7-i];
      end else if (!cmd[7]) begin
        data_drv = dat[15-i];
      end else begin
        // released: never leave the last value standing
        data_drv = ~data_drv;
      end
      #80 clk_pin = 1'b1;
      if (i >= 8) begin
        rd[15-i] = data_pin;
      end
      #80 clk_pin = 1'b0;
    end
    #400 rst_pin_n = 1'b1;
    #400;
  endtask
endmodule

/* tb/bcfg_loader_test.sv */
`timescale 1ns/1ps
module bcfg_loader_test;
  import bcfg_pkg::*;
  logic        clock, srst, por_cause, rst_n, pclk, mdl_d, dev_d, dev_oe_n;
  logic        below, lp, req, dwe, wwe, look;
  logic        den, inh, drst, grant, rreq, wre, gp, cnt, icp;
  logic [1:0]  dthr;
  logic [12:0] dmv;
  logic [3:0]  code;
  bcfg_drop_s  dwd, dctl;
  bcfg_wdt_s   wwd, wctl;
  logic [7:0]  cfg_d, cfg_w, ctl_d, ctl_w, lf, rd, dbyte, wbyte;
  logic [33:0] q[$];
  logic [33:0] e;
  int          errors, num_checks;
  // device drive wins while its enable is low
  wire         pin = (dev_oe_n === 1'b0) ? dev_d : mdl_d;
  wire [31:0]  dec_seen = {3'h0, den, dthr, dmv, inh, drst, grant, rreq, code,
                           wre, gp, cnt, icp, dev_oe_n};

  bcfg_loader uut (
    .clock(clock), .srst(srst), .por_cause(por_cause),
    .prog_reset_pin_n(rst_n), .prog_clock_pin(pclk),
    .prog_data_pin_i(pin), .prog_data_pin_o(dev_d),
    .prog_data_pin_oe_n(dev_oe_n), .supply_below(below),
    .low_power_mode(lp), .self_prog_req(req), .sw_drop_we(dwe),
    .sw_drop_wdata(dwd), .sw_wdt_we(wwe), .sw_wdt_wdata(wwd),
    .drop_ctrl(dctl), .wdt_ctrl(wctl), .supply_drop_config_byte(dbyte),
    .watchdog_config_byte(wbyte), .drop_detect_enable(den),
    .drop_threshold_select(dthr), .drop_threshold_voltage(dmv),
    .low_supply_program_inhibit(inh), .drop_reset_enable(drst),
    .self_prog_grant(grant), .drop_reset_req(rreq),
    .watchdog_enable_code(code), .wdt_reset_enable(wre),
    .wdt_gp_timer(gp), .wdt_count_enable(cnt),
    .in_circuit_programming(icp)
  );

  bcfg_prog_model prog (
    .rst_pin_n(rst_n), .clk_pin(pclk), .data_drv(mdl_d), .data_pin(pin)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [28:0] dec_exp(logic [7:0] d, logic [7:0] w,
                                          logic b, logic l, logic r);
    logic [12:0] mv;
    logic        ie;
    logic        ce;
    case (d[5:4])
      2'h3: mv = BCFG_MV_2V2;
      2'h2: mv = BCFG_MV_2V7;
      2'h1: mv = BCFG_MV_3V7;
      default: mv = BCFG_MV_4V4;
    endcase
    ie = d[7] & d[3];
    ce = (w[7:4] == 4'hF) ? 1'b0 : ((w[7:4] == 4'h5) ? ~l : 1'b1);
    return {d[7], d[5:4], mv, ie, d[2], r & ~(ie & b), d[7] & d[2] & b,
            w[7:4], w[7:4] != 4'hF, w[7:4] == 4'hF, ce, 1'b0, 1'b1};
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic note(logic [1:0] k, logic [31:0] x);
    @(posedge clock);
    q.push_back({k, x});
    look <= 1'b1;
    @(posedge clock);
    look <= 1'b0;
  endtask

  task automatic do_rst(logic p);
    srst <= 1'b1;
    por_cause <= p;
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    if (p) begin
      cfg_d = 8'hFF;
      cfg_w = 8'hFF;
      ctl_d = 8'hFF;
    end
    ctl_w = cfg_w;
  endtask

  task automatic end_sim();
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // result watcher: oldest note against what the outputs show
  always @(negedge clock) begin
    if (look === 1'b1) begin
      e = q.pop_front();
      case (e[33:32])
        2'h0: check("dec", dec_seen, e[31:0]);
        2'h1: check("bytes", {dbyte, wbyte, dctl, wctl}, e[31:0]);
        2'h2: check("readout", {24'h0, rd}, e[31:0]);
        default: check("mode", {31'h0, icp}, e[31:0]);
      endcase
    end
  end

  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    srst = 1'b1;
    por_cause = 1'b1;
    {below, lp, req, dwe, wwe, look} = 6'h00;
    dwd = 8'h00;
    wwd = 8'h00;
    lf = 8'h54;
    errors = 0;
    num_checks = 0;
    @(posedge clock);
    do_rst(1'b1);
    note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    // every watchdog code and every threshold code, random rest
    for (int i = 0; i < 16; i++) begin
      lf = lfsr(lf);
      dwd <= {lf[7:6], i[1:0], lf[3:0]};
      wwd <= {i[3:0], lf[3:0]};
      below <= lf[4];
      lp <= lf[5];
      req <= lf[6] | lf[0];
      dwe <= 1'b1;
      wwe <= 1'b1;
      @(posedge clock);
      dwe <= 1'b0;
      wwe <= 1'b0;
      ctl_d = dwd;
      ctl_w = wwd;
      repeat (6) @(posedge clock);
      note(2'h0, {3'h0, dec_exp(ctl_d, ctl_w, below, lp, req)});
      note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    end
    // reserved bits stay set; mode flag seen while the pin is held low
    fork
      prog.frame(8'h00, 8'h43, 16, rd);
      begin
        repeat (150) @(posedge clock);
        note(2'h3, 32'h1);
      end
    join
    cfg_d = 8'h43;
    prog.frame(8'h01, 8'h5F, 16, rd);
    cfg_w = 8'h5F;
    note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    // leaving the mode mid-frame loses the write
    prog.frame(8'h01, 8'h00, 6, rd);
    note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    prog.frame(8'h80, 8'h00, 16, rd);
    note(2'h2, {24'h0, cfg_d});
    prog.frame(8'h81, 8'h00, 16, rd);
    note(2'h2, {24'h0, cfg_w});
    note(2'h0, {3'h0, dec_exp(ctl_d, ctl_w, below, lp, req)});
    // warm reset keeps drop controls, reloads watchdog controls
    do_rst(1'b0);
    note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    note(2'h0, {3'h0, dec_exp(ctl_d, ctl_w, below, lp, req)});
    do_rst(1'b1);
    note(2'h1, {cfg_d, cfg_w, ctl_d, ctl_w});
    end_sim();
  end
endmodule
